// >>> lcs_pkg.sv
package lcs_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int unsigned NUM_PORTS   = 24;
	localparam int unsigned PORT_W      = 5;
	localparam int unsigned GID_W       = 9;
	localparam int unsigned STA_W       = 48;
	localparam int unsigned ADDR_W      = 16;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned AGG_W       = 5;
	localparam int unsigned CAP_W       = 63;

	// ---------------------------------------------------------------
	// word addresses on the configuration interface
	// ---------------------------------------------------------------
	localparam logic [15:0] ADDR_CONFLICT_LO = 16'h0234;
	localparam logic [15:0] ADDR_CONFLICT_HI = 16'h0235;
	localparam logic [15:0] ADDR_OVERFLOW_LO = 16'h0236;
	localparam logic [15:0] ADDR_OVERFLOW_HI = 16'h0237;
	localparam logic [15:0] ADDR_LA_CTRL     = 16'h0238;
	localparam logic [15:0] ADDR_AGG_MAP_LO  = 16'hd737;
	localparam logic [15:0] ADDR_AGG_MAP_HI  = 16'hd74e;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned BIT_LEARN_ON   = 0;
	localparam int unsigned BIT_AGE_ON     = 1;
	localparam int unsigned BIT_DEST_MARK  = 2;
	localparam int unsigned BIT_LRU        = 3;
	localparam int unsigned CTRL_W         = 4;
	localparam int unsigned BIT_CAP_VALID  = 0;
	localparam int unsigned CAP_STA_LSB    = 1;
	localparam int unsigned CAP_GID_LSB    = 49;
	localparam int unsigned CAP_PORT_LSB   = 58;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  CTRL_RESET     = 4'h7;
	localparam logic [62:0] CAP_RESET      = 63'h0000_0000_0000_0000;
	localparam logic [4:0]  AGG_RESET      = 5'h00;
endpackage

// >>> lcs_agg_map_mem.sv
`timescale 1ns/1ps
module lcs_agg_map_mem
	import lcs_pkg::*;
(
	input  wire logic               mclk,      // core clock
	input  wire logic               resetn,    // sync reset, active low
	input  wire logic               wr_en,     // write strobe
	input  wire logic [4:0]         wr_idx,    // entry written
	input  wire logic [4:0]         wr_data,   // aggregate number written
	input  wire logic [4:0]         rda_idx,   // lookup read index
	output logic      [4:0]         rda_q,     // lookup read data, registered
	input  wire logic [4:0]         rdb_idx,   // software read index
	output logic      [4:0]         rdb_q      // software read data, registered
);
	logic [4:0] ent_reg [NUM_PORTS];
	logic [4:0] rda_next;
	logic [4:0] rdb_next;

	// ---------------------------------------------------------------
	// storage, one flop group per ingress port
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_ent
		logic [4:0] ent_next;
		always_comb begin
			ent_next = ent_reg[i];
			if (wr_en && (wr_idx == 5'(i))) begin
				ent_next = wr_data;
			end
		end
		always_ff @(posedge mclk) begin
			if (!resetn) begin
				ent_reg[i] <= AGG_RESET;
			end else begin
				ent_reg[i] <= ent_next;
			end
		end
	end

	// out-of-range indices read as zero
	always_comb begin
		rda_next = (rda_idx < 5'(NUM_PORTS)) ? ent_reg[rda_idx] : AGG_RESET;
		rdb_next = (rdb_idx < 5'(NUM_PORTS)) ? ent_reg[rdb_idx] : AGG_RESET;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rda_q <= AGG_RESET;
			rdb_q <= AGG_RESET;
		end else begin
			rda_q <= rda_next;
			rdb_q <= rdb_next;
		end
	end
endmodule // lcs_agg_map_mem

// >>> lcs_l2_learning_control_status.sv
`timescale 1ns/1ps
module lcs_l2_learning_control_status
	import lcs_pkg::*;
(
	input  wire logic                 mclk,               // core clock, 40 MHz
	input  wire logic                 resetn,             // sync reset, active low
	input  wire logic                 cfg_wr,             // configuration write strobe
	input  wire logic                 cfg_rd,             // configuration read strobe
	input  wire logic [15:0]          cfg_addr,           // word address
	input  wire logic [31:0]          cfg_wdata,          // write data
	output logic      [31:0]          cfg_rdata,          // read data
	output logic                      cfg_rvalid,         // read data valid
	output logic                      learn_unit_on,      // learning unit enable
	output logic                      age_unit_on,        // aging unit enable
	input  wire logic                 da_match,           // destination match pulse
	input  wire logic                 da_entry_static,    // matched entry is static
	output logic                      dest_hit_mark,      // set hit bit of matched entry
	output logic                      repl_hash_ok,       // replacement may use hash table
	output logic                      repl_coll_ok,       // replacement may use collision table
	input  wire logic                 move_fail,          // port move failed pulse
	input  wire logic                 static_conflict,    // pairing hits a static entry
	input  wire logic [4:0]           prev_port,          // port bound in the static entry
	input  wire logic [23:0]          static_move_permit_mask, // per-port move permission
	output logic                      static_rebind,      // rebind static entry to new port
	input  wire logic                 learn_full,         // no free slot pulse
	input  wire logic [47:0]          ev_station_address, // address of the failing pairing
	input  wire logic [8:0]           ev_gid,             // group identifier of the failure
	input  wire logic [4:0]           ev_port,            // source port of the failure
	input  wire logic                 agg_enable,         // link aggregation enabled
	input  wire logic                 src_req,            // source lookup request
	input  wire logic [4:0]           src_port,           // physical ingress port
	output logic                      lookup_valid,       // lookup port valid
	output logic      [4:0]           lookup_port         // port used by source lookup
);
	import lcs_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [3:0]  ctrl_reg,     ctrl_next;
	logic [62:0] conf_reg,     conf_next;
	logic [62:0] ovfl_reg,     ovfl_next;
	logic [31:0] rd_hold_reg,  rd_hold_next;
	logic        rd_mem_reg,   rd_mem_next;
	logic        rvalid_reg,   rvalid_next;
	logic        lk_valid_reg, lk_valid_next;
	logic        lk_agg_reg,   lk_agg_next;
	logic [4:0]  lk_port_reg,  lk_port_next;
	logic [4:0]  mem_lk_q;
	logic [4:0]  mem_sw_q;
	logic        map_hit;
	logic [4:0]  map_idx;
	logic        conf_event;
	logic        conf_clear;
	logic        ovfl_clear;
	logic [62:0] ev_word;

	// ---------------------------------------------------------------
	// control outputs
	// ---------------------------------------------------------------
	// learning gate
	assign learn_unit_on = ctrl_reg[BIT_LEARN_ON];
	assign age_unit_on   = ctrl_reg[BIT_AGE_ON];
	assign dest_hit_mark = ctrl_reg[BIT_DEST_MARK] && da_match && !da_entry_static;
	// the collision table is always a candidate; the lru bit only widens it
	// lru scope
	assign repl_hash_ok  = ctrl_reg[BIT_LRU];
	assign repl_coll_ok  = 1'b1;
	// static move permission; out-of-range ports never move
	assign static_rebind = static_conflict && (prev_port < 5'(NUM_PORTS))
		&& static_move_permit_mask[prev_port];
	// a refused static move is reported like any other failed move
	assign conf_event    = move_fail || (static_conflict && !static_rebind);

	// ---------------------------------------------------------------
	// capture words
	// ---------------------------------------------------------------
	// capture layout, shared by both status registers
	assign ev_word    = {ev_port, ev_gid, ev_station_address, 1'b1};
	// only a zero in the valid bit clears
	assign conf_clear = cfg_wr && (cfg_addr == ADDR_CONFLICT_LO) && !cfg_wdata[BIT_CAP_VALID];
	assign ovfl_clear = cfg_wr && (cfg_addr == ADDR_OVERFLOW_LO) && !cfg_wdata[BIT_CAP_VALID];
	assign map_hit    = (cfg_addr >= ADDR_AGG_MAP_LO) && (cfg_addr <= ADDR_AGG_MAP_HI);
	assign map_idx    = 5'(cfg_addr - ADDR_AGG_MAP_LO);

	// is software's duty; the control word has no partial-clear guard
	always_comb begin
		ctrl_next = ctrl_reg;
		conf_next = conf_reg;
		ovfl_next = ovfl_reg;
		// capture high words have no write path: they are status only
		if (cfg_wr && (cfg_addr == ADDR_LA_CTRL)) begin
			ctrl_next = cfg_wdata[CTRL_W-1:0];
		end
		if (conf_clear) begin
			conf_next[BIT_CAP_VALID] = 1'b0;
		end
		// hold while valid; an event beside a clear is kept (set wins)
		if (conf_event && (!conf_reg[BIT_CAP_VALID] || conf_clear)) begin
			conf_next = ev_word;
		end
		if (ovfl_clear) begin
			ovfl_next[BIT_CAP_VALID] = 1'b0;
		end
		if (learn_full && (!ovfl_reg[BIT_CAP_VALID] || ovfl_clear)) begin
			ovfl_next = ev_word;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_reg <= CTRL_RESET;
			conf_reg <= CAP_RESET;
			ovfl_reg <= CAP_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			conf_reg <= conf_next;
			ovfl_reg <= ovfl_next;
		end
	end

	// ---------------------------------------------------------------
	// read path, one cycle latency, unmapped reads return zero
	// ---------------------------------------------------------------
	always_comb begin
		rd_hold_next = 32'h0000_0000;
		rd_mem_next  = 1'b0;
		rvalid_next  = cfg_rd;
		if (cfg_rd) begin
			if (cfg_addr == ADDR_CONFLICT_LO) begin
				rd_hold_next = conf_reg[31:0];
			end else if (cfg_addr == ADDR_CONFLICT_HI) begin
				rd_hold_next = {1'b0, conf_reg[62:32]};
			end else if (cfg_addr == ADDR_OVERFLOW_LO) begin
				rd_hold_next = ovfl_reg[31:0];
			end else if (cfg_addr == ADDR_OVERFLOW_HI) begin
				rd_hold_next = {1'b0, ovfl_reg[62:32]};
			end else if (cfg_addr == ADDR_LA_CTRL) begin
				rd_hold_next = {28'h000_0000, ctrl_reg};
			end else if (map_hit) begin
				rd_mem_next = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rd_hold_reg <= 32'h0000_0000;
			rd_mem_reg  <= 1'b0;
			rvalid_reg  <= 1'b0;
		end else begin
			rd_hold_reg <= rd_hold_next;
			rd_mem_reg  <= rd_mem_next;
			rvalid_reg  <= rvalid_next;
		end
	end

	assign cfg_rvalid = rvalid_reg;
	// the map read port runs every cycle; rd_mem_reg decides when it is shown
	assign cfg_rdata  = rd_mem_reg ? {27'h000_0000, mem_sw_q} : rd_hold_reg;

	// ---------------------------------------------------------------
	// aggregate membership and source lookup
	// ---------------------------------------------------------------
	lcs_agg_map_mem i_lcs_agg_map_mem (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (cfg_wr && map_hit),
		.wr_idx  (map_idx),
		.wr_data (cfg_wdata[AGG_W-1:0]),
		.rda_idx (src_port),
		.rda_q   (mem_lk_q),
		.rdb_idx (map_idx),
		.rdb_q   (mem_sw_q)
	);

	// agg_enable is taken with the request, so a toggle cannot split a lookup
	always_comb begin
		lk_valid_next = src_req;
		lk_agg_next   = src_req && agg_enable;
		lk_port_next  = src_req ? src_port : lk_port_reg;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lk_valid_reg <= 1'b0;
			lk_agg_reg   <= 1'b0;
			lk_port_reg  <= 5'h00;
		end else begin
			lk_valid_reg <= lk_valid_next;
			lk_agg_reg   <= lk_agg_next;
			lk_port_reg  <= lk_port_next;
		end
	end

	assign lookup_valid = lk_valid_reg;
	assign lookup_port  = lk_agg_reg ? mem_lk_q : lk_port_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	AST_LEARN_GATE: assert property (
		cfg_wr && cfg_addr == ADDR_LA_CTRL |=> learn_unit_on == $past(cfg_wdata[0]))
		else $error("learning enable does not follow control write");
	AST_AGE_GATE: assert property (
		cfg_wr && cfg_addr == ADDR_LA_CTRL |=> age_unit_on == $past(cfg_wdata[1]))
		else $error("aging enable does not follow control write");
	AST_HIT_STATIC: assert property (
		da_match && da_entry_static |-> !dest_hit_mark)
		else $error("hit marked on a static entry");
	AST_HIT_MARK: assert property (
		cfg_wr && cfg_addr == ADDR_LA_CTRL && cfg_wdata[2] ##1 da_match && !da_entry_static
		|-> dest_hit_mark)
		else $error("hit not marked while enabled");
	AST_LRU_SCOPE: assert property (
		cfg_wr && cfg_addr == ADDR_LA_CTRL |=> repl_hash_ok == $past(cfg_wdata[3]) && repl_coll_ok)
		else $error("replacement scope wrong");
	AST_CONF_CAPTURE: assert property (
		move_fail && !conf_reg[0] |=> conf_reg[62:1] ==
		{$past(ev_port), $past(ev_gid), $past(ev_station_address)})
		else $error("conflict fields not captured");
	AST_CONF_VALID: assert property (
		conf_event |=> conf_reg[0])
		else $error("conflict valid not set");
	AST_OVFL_CAPTURE: assert property (
		learn_full && !ovfl_reg[0] |=> ovfl_reg[62:58] == $past(ev_port) && ovfl_reg[0])
		else $error("overflow not captured");
	AST_CONF_HOLD: assert property (
		conf_reg[0] && !conf_clear |=> $stable(conf_reg))
		else $error("conflict register overwritten while valid");
	AST_OVFL_HOLD: assert property (
		ovfl_reg[0] && !ovfl_clear |=> $stable(ovfl_reg))
		else $error("overflow register overwritten while valid");
	AST_PHYS_PORT: assert property (
		src_req && !agg_enable |=> lookup_valid && lookup_port == $past(src_port))
		else $error("physical port not used without aggregation");
	AST_STATIC_DENY: assert property (
		static_conflict && prev_port < 5'(NUM_PORTS) && !static_move_permit_mask[prev_port]
		&& !conf_reg[0] |=> conf_reg[0])
		else $error("denied static move not recorded");
	AST_SET_ONE_NOP: assert property (
		cfg_wr && cfg_addr == ADDR_OVERFLOW_LO && cfg_wdata[0] && !ovfl_reg[0] && !learn_full
		|=> !ovfl_reg[0])
		else $error("writing one set the overflow valid flag");
	AST_HIT_OFF: assert property (
		cfg_wr && cfg_addr == ADDR_LA_CTRL && !cfg_wdata[2] |=> !dest_hit_mark)
		else $error("hit marked while marking disabled");
	AST_CONF_CLEAR: assert property (
		conf_clear && !conf_event |=> !conf_reg[0])
		else $error("conflict valid not cleared by zero write");
	AST_OVFL_VALID: assert property (
		learn_full |=> ovfl_reg[0])
		else $error("overflow valid not set");
	AST_OVFL_FIELDS: assert property (
		learn_full && !ovfl_reg[0] |=> ovfl_reg[57:1] ==
		{$past(ev_gid), $past(ev_station_address)})
		else $error("overflow group or address not captured");
	AST_OVFL_CLEAR: assert property (
		ovfl_clear && !learn_full |=> !ovfl_reg[0])
		else $error("overflow valid not cleared by zero write");
	AST_AGG_RANGE: assert property (
		src_req && agg_enable && src_port >= 5'(NUM_PORTS) |=> lookup_port == 5'h00)
		else $error("out-of-range ingress port not mapped to zero");
	AST_LOOKUP_PULSE: assert property (
		!src_req |=> !lookup_valid)
		else $error("lookup valid without a request");
	AST_MOVE_QUIET: assert property (
		static_rebind && !move_fail && !conf_reg[0] |=> !conf_reg[0])
		else $error("permitted static move recorded as conflict");

	// ---------------------------------------------------------------
	// cover points
	// ---------------------------------------------------------------
	COV_CONF: cover property (move_fail ##1 conf_reg[0] ##[1:20] conf_clear);
	COV_OVFL: cover property (learn_full ##1 ovfl_reg[0]);
	COV_AGG: cover property (src_req && agg_enable ##1 lookup_valid);
	COV_REBIND: cover property (static_rebind);
	COV_HIT: cover property (dest_hit_mark);
endmodule // lcs_l2_learning_control_status

// >>> lcs_l2_learning_control_status_test.sv
`timescale 1ns/1ps
module lcs_l2_learning_control_status_test;
	import lcs_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        mclk, resetn, cfg_wr, cfg_rd, cfg_rvalid;
	logic [15:0] cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic        learn_unit_on, age_unit_on, da_match, da_entry_static, dest_hit_mark;
	logic        repl_hash_ok, repl_coll_ok, move_fail, static_conflict, static_rebind;
	logic [4:0]  prev_port, ev_port, src_port, lookup_port;
	logic [23:0] static_move_permit_mask;
	logic        learn_full, agg_enable, src_req, lookup_valid;
	logic [47:0] ev_station_address;
	logic [8:0]  ev_gid;
	int          n_mismatch = 0;
	int          n_checks   = 0;
	// two distinct failure records: port, group, address, valid
	logic [62:0] cap_a = {5'h07, 9'h1a5, 48'h0123_4567_89ab, 1'b1};
	logic [62:0] cap_b = {5'h17, 9'h05a, 48'hfedc_ba98_7654, 1'b1};

	lcs_l2_learning_control_status i_lcs_l2_learning_control_status (
		.mclk                    (mclk),
		.resetn                  (resetn),
		.cfg_wr                  (cfg_wr),
		.cfg_rd                  (cfg_rd),
		.cfg_addr                (cfg_addr),
		.cfg_wdata               (cfg_wdata),
		.cfg_rdata               (cfg_rdata),
		.cfg_rvalid              (cfg_rvalid),
		.learn_unit_on           (learn_unit_on),
		.age_unit_on             (age_unit_on),
		.da_match                (da_match),
		.da_entry_static         (da_entry_static),
		.dest_hit_mark           (dest_hit_mark),
		.repl_hash_ok            (repl_hash_ok),
		.repl_coll_ok            (repl_coll_ok),
		.move_fail               (move_fail),
		.static_conflict         (static_conflict),
		.prev_port               (prev_port),
		.static_move_permit_mask (static_move_permit_mask),
		.static_rebind           (static_rebind),
		.learn_full              (learn_full),
		.ev_station_address      (ev_station_address),
		.ev_gid                  (ev_gid),
		.ev_port                 (ev_port),
		.agg_enable              (agg_enable),
		.src_req                 (src_req),
		.src_port                (src_port),
		.lookup_valid            (lookup_valid),
		.lookup_port             (lookup_port)
	);

	always #12.5 mclk = ~mclk;

	// ---------------------------------------------------------------
	// bus and event tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [62:0] seen, input logic [62:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk) #2;
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(posedge mclk) #2;
		cfg_wr = 1'b0;
	endtask

	// compares only the bits set in m
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge mclk) #2;
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(posedge mclk) #2;
		cfg_rd = 1'b0;
		chk({62'h0, cfg_rvalid}, 63'h1);
		chk({31'h0, cfg_rdata & m}, {31'h0, e & m});
	endtask

	task automatic capchk(input logic [15:0] a, input logic [62:0] e);
		rd(a, e[31:0], 32'hffff_ffff);
		rd(16'(a + 16'h0001), {1'b0, e[62:32]}, 32'hffff_ffff);
	endtask

	// kind 0: port move failure, kind 1: no free slot
	task automatic ev(input int kind, input logic [62:0] c);
		@(posedge mclk) #2;
		ev_station_address = c[48:1];
		ev_gid = c[57:49];
		ev_port = c[62:58];
		if (kind == 0) begin
			move_fail = 1'b1;
		end else begin
			learn_full = 1'b1;
		end
		@(posedge mclk) #2;
		move_fail = 1'b0;
		learn_full = 1'b0;
	endtask

	task automatic lk(input logic [4:0] p, input logic en, input logic [4:0] e);
		@(posedge mclk) #2;
		src_req = 1'b1;
		src_port = p;
		agg_enable = en;
		@(posedge mclk) #2;
		src_req = 1'b0;
		chk({62'h0, lookup_valid}, 63'h1);
		chk({58'h0, lookup_port}, {58'h0, e});
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// watchdog: whole sequence takes about 115 cycles
	// ---------------------------------------------------------------
	initial begin
		#50000;
		n_mismatch++;
		summarize();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 16'h0000;
		cfg_wdata = 32'h0000_0000;
		da_match = 1'b0;
		da_entry_static = 1'b0;
		move_fail = 1'b0;
		learn_full = 1'b0;
		static_conflict = 1'b0;
		prev_port = 5'h00;
		static_move_permit_mask = 24'h00_0000;
		ev_station_address = 48'h0000_0000_0000;
		ev_gid = 9'h000;
		ev_port = 5'h00;
		agg_enable = 1'b0;
		src_req = 1'b0;
		src_port = 5'h00;
		repeat (10) @(posedge mclk);
		#2 resetn = 1'b1;
		rd(ADDR_LA_CTRL, 32'h0000_0007, 32'hffff_ffff);
		chk({61'h0, learn_unit_on, age_unit_on}, 63'h3);
		chk({61'h0, repl_hash_ok, repl_coll_ok}, 63'h1);
		capchk(ADDR_CONFLICT_LO, 63'h0);
		capchk(ADDR_OVERFLOW_LO, 63'h0);
		// hit marking skips static entries
		da_match = 1'b1;
		#1 chk({62'h0, dest_hit_mark}, 63'h1);
		@(posedge mclk) #2;
		da_entry_static = 1'b1;
		#1 chk({62'h0, dest_hit_mark}, 63'h0);
		@(posedge mclk) #2;
		da_entry_static = 1'b0;
		wr(ADDR_LA_CTRL, 32'h0000_000b);
		chk({62'h0, dest_hit_mark}, 63'h0);
		chk({61'h0, repl_hash_ok, repl_coll_ok}, 63'h3);
		da_match = 1'b0;
		wr(ADDR_LA_CTRL, 32'h0000_0002);
		chk({61'h0, learn_unit_on, age_unit_on}, 63'h1);
		wr(ADDR_LA_CTRL, 32'h0000_0001);
		chk({61'h0, learn_unit_on, age_unit_on}, 63'h2);
		// marking switched back on by a write, match in the next cycle
		wr(ADDR_LA_CTRL, 32'h0000_0004);
		da_match = 1'b1;
		#1 chk({62'h0, dest_hit_mark}, 63'h1);
		chk({61'h0, learn_unit_on, age_unit_on}, 63'h0);
		@(posedge mclk) #2;
		da_match = 1'b0;
		// full hand-over to software clears every field at once
		// software duty
		wr(ADDR_LA_CTRL, 32'h0000_0000);
		rd(ADDR_LA_CTRL, 32'h0000_0000, 32'hffff_ffff);
		// conflict capture, hold, ignored writes, clear, recapture
		ev(0, cap_a);
		capchk(ADDR_CONFLICT_LO, cap_a);
		ev(0, cap_b);
		capchk(ADDR_CONFLICT_LO, cap_a);
		wr(ADDR_CONFLICT_LO, 32'h0000_0001);
		wr(ADDR_CONFLICT_HI, 32'hffff_ffff);
		capchk(ADDR_CONFLICT_LO, cap_a);
		wr(ADDR_CONFLICT_LO, 32'h0000_0000);
		rd(ADDR_CONFLICT_LO, 32'h0000_0000, 32'h0000_0001);
		ev(0, cap_b);
		capchk(ADDR_CONFLICT_LO, cap_b);
		// overflow capture behaves alike
		ev(1, cap_b);
		capchk(ADDR_OVERFLOW_LO, cap_b);
		ev(1, cap_a);
		capchk(ADDR_OVERFLOW_LO, cap_b);
		wr(ADDR_OVERFLOW_LO, 32'h0000_0000);
		rd(ADDR_OVERFLOW_LO, 32'h0000_0000, 32'h0000_0001);
		wr(ADDR_OVERFLOW_LO, 32'h0000_0001);
		rd(ADDR_OVERFLOW_LO, 32'h0000_0000, 32'h0000_0001);
		// static move: permitted port rebinds, other port is a conflict
		wr(ADDR_CONFLICT_LO, 32'h0000_0000);
		static_move_permit_mask = 24'h00_0008;
		@(posedge mclk) #2;
		ev_station_address = cap_a[48:1];
		ev_gid = cap_a[57:49];
		ev_port = cap_a[62:58];
		static_conflict = 1'b1;
		prev_port = 5'h03;
		#1 chk({62'h0, static_rebind}, 63'h1);
		@(posedge mclk) #2;
		prev_port = 5'h04;
		#1 chk({62'h0, static_rebind}, 63'h0);
		@(posedge mclk) #2;
		static_conflict = 1'b0;
		capchk(ADDR_CONFLICT_LO, cap_a);
		// aggregate substitution, port 3 and last port
		wr(16'(ADDR_AGG_MAP_LO + 16'h0003), 32'h0000_0015);
		wr(ADDR_AGG_MAP_HI, 32'h0000_001e);
		rd(16'(ADDR_AGG_MAP_LO + 16'h0003), 32'h0000_0015, 32'hffff_ffff);
		lk(5'h03, 1'b1, 5'h15);
		lk(5'h17, 1'b1, 5'h1e);
		lk(5'h03, 1'b0, 5'h03);
		lk(5'h05, 1'b1, 5'h00);
		lk(5'h1f, 1'b1, 5'h00);
		// unmapped word reads zero and ignores writes
		wr(16'h0239, 32'hffff_ffff);
		rd(16'h0239, 32'h0000_0000, 32'hffff_ffff);
		summarize();
	end
endmodule // lcs_l2_learning_control_status_test
